// ### logic/dgp_params.svh
// Constants of the dual GPIO port: register offsets, field positions and
// reset values. Assumes a 32-bit classic Wishbone slave with byte addresses.
`ifndef DGP_PARAMS_SVH
`define DGP_PARAMS_SVH

// ==========================================================================
// Register byte offsets
`define DGP_OFS_A_DATA      8'h00
`define DGP_OFS_A_DIR       8'h04
`define DGP_OFS_B_DATA      8'h08
`define DGP_OFS_B_DIR       8'h0c
`define DGP_OFS_EXT_MODE    8'h10
`define DGP_OFS_PULLUP      8'h14
`define DGP_OFS_HOLD        8'h18
`define DGP_OFS_REFRESH     8'h1c
`define DGP_OFS_WAIT1       8'h20
`define DGP_OFS_WAIT2       8'h24
`define DGP_OFS_BITOP       8'h28
`define DGP_OFS_STATUS      8'h2c

// ==========================================================================
// Field positions
`define DGP_PULLUP_A_BIT    6
`define DGP_HOLD_EN_BIT     0
`define DGP_REFRESH_EN_BIT  0
`define DGP_BITOP_PORT_BIT  4
`define DGP_BITOP_SET_BIT   3
`define DGP_WAIT_EXT_CODE   2'b11

// ==========================================================================
// Reset values
`define DGP_DIR_RST         8'hff
`define DGP_LATCH_RST       8'h00
`define DGP_MODE_RST        4'h0
`define DGP_CTL_RST         8'h00

`endif

// ### logic/dgp_pkg.sv
// Types shared by the dual GPIO port files.
// Assumes nothing beyond a SystemVerilog compiler.
package dgp_pkg;

   // ========================================================================
   // Pin drive bundle: level and output enable per pin
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } dgp_pins_s;

   // ========================================================================
   // Owner of port A bit 7
   typedef enum logic [1:0] {
      DGP_B7_PORT,
      DGP_B7_HOLD,
      DGP_B7_REFRESH
   } dgp_b7_owner_e;

endpackage

// ### logic/dgp_wb_slave.sv
// Classic Wishbone slave front end of the dual GPIO port.
// Assumes the master holds its request until it sees ack.
`timescale 1ns/1ps

module dgp_wb_slave
#(
   parameter int AW = 8
)
(
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   input  wire logic          wb_we_i,
   input  wire logic [AW-1:0] wb_adr_i,
   input  wire logic [3:0]    wb_sel_i,
   input  wire logic [31:0]   wb_dat_i,
   output logic      [31:0]   wb_dat_o,
   output logic               wb_ack_o,
   input  wire logic [7:0]    rd_byte_i,
   output logic               wr_stb_o,
   output logic      [7:0]    wr_byte_o
);
   logic        ack_reg;
   logic [31:0] dat_reg;
   wire         req = wb_cyc_i & wb_stb_i;

   // Elaboration check on address width
   if (AW < 6)
   begin : g_bad_aw
      $error("dgp_wb_slave: AW must be at least 6");
   end

   // ========================================================================
   // One wait state: ack in the cycle after the request, read data with it
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h0000_0000;
      end
      else
      begin
         ack_reg <= req & ~ack_reg;
         dat_reg <= {24'h00_0000, rd_byte_i};
      end
   end

   // Write takes effect on the edge at which the master samples ack
   assign wr_stb_o  = req & wb_we_i & ack_reg & wb_sel_i[0];
   assign wr_byte_o = wb_dat_i[7:0];
   assign wb_ack_o  = ack_reg;
   assign wb_dat_o  = dat_reg;

endmodule

// ### logic/dgp_port_bits.sv
// One bidirectional port: output latch, direction register, read path.
// Assumes pin inputs are synchronous to clk_i; control owner drives masks.
`include "dgp_params.svh"
`timescale 1ns/1ps

module dgp_port_bits
#(
   parameter int W = 8
)
(
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         latch_we_i,
   input  wire logic [W-1:0] latch_d_i,
   input  wire logic         dir_we_i,
   input  wire logic [W-1:0] dir_d_i,
   input  wire logic [W-1:0] pin_i,
   input  wire logic [W-1:0] ctl_mask_i,
   input  wire logic [W-1:0] ctl_out_i,
   input  wire logic [W-1:0] ctl_oe_i,
   output logic      [W-1:0] pin_o,
   output logic      [W-1:0] pin_oe_o,
   output logic      [W-1:0] rd_o,
   output logic      [W-1:0] dir_o,
   output logic      [W-1:0] latch_o
);
   logic [W-1:0] latch_reg;
   logic [W-1:0] dir_reg;

   if (W < 1 || W > 8)
   begin : g_bad_w
      $error("dgp_port_bits: W must be 1 to 8");
   end

   // ========================================================================
   // Latch takes every written bit, input or output alike
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         latch_reg <= W'(`DGP_LATCH_RST);
         dir_reg   <= W'(`DGP_DIR_RST);
      end
      else
      begin
         if (latch_we_i)
            latch_reg <= latch_d_i;
         if (dir_we_i)
            dir_reg <= dir_d_i;
      end
   end

   // ========================================================================
   // Per-bit drive and read selection
   for (genvar n = 0; n < W; n++)
   begin : g_bit
      assign pin_o[n]    = ctl_mask_i[n] ? ctl_out_i[n] : latch_reg[n];
      assign pin_oe_o[n] = ctl_mask_i[n] ? ctl_oe_i[n] : ~dir_reg[n];
      assign rd_o[n]     = ctl_mask_i[n] ? 1'b0
                         : (dir_reg[n] ? pin_i[n] : latch_reg[n]);
   end

   assign dir_o   = dir_reg;
   assign latch_o = latch_reg;

endmodule

// ### logic/dgp_gpio.sv
// Dual 8-bit GPIO port with memory-bus pin sharing, classic Wishbone regs.
// Assumes one 200 MHz clock, synchronous pins and a core that supplies the
// upper address, strobes, hold acknowledge and refresh pulses.
//
// Contract
// - Extension mode field picks address and strobe pins
// - Unclaimed port A pins act as plain I/O
// - Output bit driven from latch, latch holds
// - Output bit reads back latch; writes update it
// - Input bit reads the pin level
// - Port write stores every latch bit
// - Input bit driver is high impedance
// - Turning output drives stored latch at once
// - No read path to input bit latch
// - Bit set/clear is whole-port read-modify-write
// - Control pins ignore writes, read as zero
// - Pull-up on input A pins when enabled
// - Port B direction per bit, own register
// - Port B pins readable at any time
// - Port B resets to all inputs
// - Analog inputs always available, no mode
// - Port B has no pull-ups
// - Port A resets to all inputs
// - Bit 6 hold request, bit 7 hold acknowledge
// - Bit 7 refresh request when refresh enabled; here hold owns bit 7 when both are enabled
// - Bit 6 wait input when selected or input
//
// Design decisions made here: register access over Wishbone and the register offsets.
`include "dgp_params.svh"
`timescale 1ns/1ps

module dgp_gpio
#(
   parameter int AW = 8
)
(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [AW-1:0]     wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   input  wire logic [7:0]        port_a_pins_i,
   output dgp_pkg::dgp_pins_s     port_a_pins_o,
   output logic      [7:0]        port_a_pullup_o,
   input  wire logic [7:0]        port_b_pins_i,
   output dgp_pkg::dgp_pins_s     port_b_pins_o,
   output logic      [7:0]        analog_inputs_o,
   input  wire logic [3:0]        upper_address_i,
   input  wire logic              read_strobe_n_i,
   input  wire logic              write_strobe_n_i,
   input  wire logic              bus_hold_ack_i,
   input  wire logic              refresh_pulse_i,
   output logic                   bus_hold_request_o,
   output logic                   ext_wait_n_o
);
   import dgp_pkg::*;

   // ========================================================================
   // Configuration registers
   logic [3:0] memory_extension_mode_reg;
   logic [7:0] pullup_option_reg;
   logic [7:0] hold_mode_reg;
   logic [7:0] refresh_mode_reg;
   logic [7:0] wait_control_reg_one;
   logic [7:0] wait_control_reg_two;

   // Bus side signals
   logic       wr_stb;
   logic [7:0] wr_byte;
   logic [7:0] rd_byte;
   wire  [7:0] adr8 = 8'(wb_adr_i);

   // Port side signals
   logic [7:0] a_rd;
   logic [7:0] a_dir;
   logic [7:0] a_latch;
   logic [7:0] a_out;
   logic [7:0] a_oe;
   logic [7:0] b_rd;
   logic [7:0] b_dir;
   logic [7:0] b_latch;
   logic [7:0] b_out;
   logic [7:0] b_oe;

   // ========================================================================
   // Address decode
   wire sel_a_data  = (adr8 == `DGP_OFS_A_DATA);
   wire sel_a_dir   = (adr8 == `DGP_OFS_A_DIR);
   wire sel_b_data  = (adr8 == `DGP_OFS_B_DATA);
   wire sel_b_dir   = (adr8 == `DGP_OFS_B_DIR);
   wire sel_mode    = (adr8 == `DGP_OFS_EXT_MODE);
   wire sel_pullup  = (adr8 == `DGP_OFS_PULLUP);
   wire sel_hold    = (adr8 == `DGP_OFS_HOLD);
   wire sel_refresh = (adr8 == `DGP_OFS_REFRESH);
   wire sel_wait1   = (adr8 == `DGP_OFS_WAIT1);
   wire sel_wait2   = (adr8 == `DGP_OFS_WAIT2);
   wire sel_bitop   = (adr8 == `DGP_OFS_BITOP);
   wire sel_status  = (adr8 == `DGP_OFS_STATUS);

   // ========================================================================
   // Wishbone front end
   dgp_wb_slave #(.AW(AW)) u_bus
   (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .wb_cyc_i  (wb_cyc_i),
      .wb_stb_i  (wb_stb_i),
      .wb_we_i   (wb_we_i),
      .wb_adr_i  (wb_adr_i),
      .wb_sel_i  (wb_sel_i),
      .wb_dat_i  (wb_dat_i),
      .wb_dat_o  (wb_dat_o),
      .wb_ack_o  (wb_ack_o),
      .rd_byte_i (rd_byte),
      .wr_stb_o  (wr_stb),
      .wr_byte_o (wr_byte)
   );

   // ========================================================================
   // Control-pin ownership of port A
   wire hold_en    = hold_mode_reg[`DGP_HOLD_EN_BIT];
   wire refresh_en = refresh_mode_reg[`DGP_REFRESH_EN_BIT];
   wire pullup_en  = pullup_option_reg[`DGP_PULLUP_A_BIT];

   // Modes 0100-0111 give strobes; 1000 and 1001 add address pins
   wire mode_strobe = (memory_extension_mode_reg[3:2] == 2'b01)
                    | (memory_extension_mode_reg[3:1] == 3'b100);
   wire mode_a17    = (memory_extension_mode_reg[3:1] == 3'b100);
   wire mode_a19    = (memory_extension_mode_reg == 4'h9);

   // External wait chosen by any wait field at the external code
   logic [7:0] wait_fields_ext;
   for (genvar f = 0; f < 4; f++)
   begin : g_wait
      assign wait_fields_ext[f]   = (wait_control_reg_one[2*f+1 -: 2]
                                     == `DGP_WAIT_EXT_CODE);
      assign wait_fields_ext[f+4] = (wait_control_reg_two[2*f+1 -: 2]
                                     == `DGP_WAIT_EXT_CODE);
   end
   wire ext_wait_sel = |wait_fields_ext;

   // Hold takes bit 7 ahead of refresh: a held bus cannot be refreshed
   dgp_b7_owner_e b7_owner;
   assign b7_owner = hold_en    ? DGP_B7_HOLD
                   : refresh_en ? DGP_B7_REFRESH
                   : DGP_B7_PORT;

   logic b7_ctl;
   logic b7_level;
   always_comb
   begin
      b7_ctl   = 1'b0;
      b7_level = 1'b0;
      unique case (b7_owner)
         DGP_B7_PORT:
         begin
            b7_ctl   = 1'b0;
            b7_level = 1'b0;
         end
         DGP_B7_HOLD:
         begin
            b7_ctl   = 1'b1;
            b7_level = bus_hold_ack_i;
         end
         DGP_B7_REFRESH:
         begin
            b7_ctl   = 1'b1;
            b7_level = refresh_pulse_i;
         end
      endcase
   end

   // Pins not claimed here stay ordinary I/O
   wire b6_ctl = hold_en | ext_wait_sel;
   wire [7:0] a_ctl_mask = {b7_ctl, b6_ctl, {2{mode_strobe}},
                            {2{mode_a19}}, {2{mode_a17 | mode_a19}}};
   wire [7:0] a_ctl_out  = {b7_level, 1'b0, write_strobe_n_i,
                            read_strobe_n_i, upper_address_i};
   // Bit 6 is only ever an input in control mode
   wire [7:0] a_ctl_oe   = 8'hbf;

   // Wait input also follows the pin whenever bit 6 is set as input
   wire wait_active = ext_wait_sel | a_dir[6];
   assign ext_wait_n_o       = wait_active ? port_a_pins_i[6] : 1'b1;
   assign bus_hold_request_o = hold_en & port_a_pins_i[6];

   // ========================================================================
   // Single-bit set/clear: read whole port, change one bit, write back
   wire        bitop_b   = wr_byte[`DGP_BITOP_PORT_BIT];
   wire        bitop_set = wr_byte[`DGP_BITOP_SET_BIT];
   wire [2:0]  bitop_idx = wr_byte[2:0];
   wire [7:0]  bitop_src = bitop_b ? b_rd : a_rd;
   wire [7:0]  bitop_msk = 8'h01 << bitop_idx;
   wire [7:0]  bitop_val = bitop_set ? (bitop_src | bitop_msk)
                                     : (bitop_src & ~bitop_msk);
   wire        bitop_wr  = wr_stb & sel_bitop;

   // Latch write strobes and data for both ports
   wire       a_latch_we = (wr_stb & sel_a_data) | (bitop_wr & ~bitop_b);
   wire       b_latch_we = (wr_stb & sel_b_data) | (bitop_wr & bitop_b);
   wire [7:0] latch_d    = bitop_wr ? bitop_val : wr_byte;

   // ========================================================================
   // Port A: control functions overlay the plain I/O bits
   dgp_port_bits #(.W(8)) u_port_a
   (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .latch_we_i (a_latch_we),
      .latch_d_i  (latch_d),
      .dir_we_i   (wr_stb & sel_a_dir),
      .dir_d_i    (wr_byte),
      .pin_i      (port_a_pins_i),
      .ctl_mask_i (a_ctl_mask),
      .ctl_out_i  (a_ctl_out),
      .ctl_oe_i   (a_ctl_oe),
      .pin_o      (a_out),
      .pin_oe_o   (a_oe),
      .rd_o       (a_rd),
      .dir_o      (a_dir),
      .latch_o    (a_latch)
   );

   // Port B: no control functions, own direction register
   dgp_port_bits #(.W(8)) u_port_b
   (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .latch_we_i (b_latch_we),
      .latch_d_i  (latch_d),
      .dir_we_i   (wr_stb & sel_b_dir),
      .dir_d_i    (wr_byte),
      .pin_i      (port_b_pins_i),
      .ctl_mask_i (8'h00),
      .ctl_out_i  (8'h00),
      .ctl_oe_i   (8'h00),
      .pin_o      (b_out),
      .pin_oe_o   (b_oe),
      .rd_o       (b_rd),
      .dir_o      (b_dir),
      .latch_o    (b_latch)
   );

   assign port_a_pins_o = '{out: a_out, oe: a_oe};
   assign port_b_pins_o = '{out: b_out, oe: b_oe};

   // Pull-ups only on port A inputs; port B has none at all
   assign port_a_pullup_o = {8{pullup_en}} & a_dir;
   // Converter taps the pins with no mode gating
   assign analog_inputs_o = port_b_pins_i;

   // ========================================================================
   // Configuration register writes
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         memory_extension_mode_reg <= `DGP_MODE_RST;
         pullup_option_reg         <= `DGP_CTL_RST;
         hold_mode_reg             <= `DGP_CTL_RST;
         refresh_mode_reg          <= `DGP_CTL_RST;
         wait_control_reg_one      <= `DGP_CTL_RST;
         wait_control_reg_two      <= `DGP_CTL_RST;
      end
      else if (wr_stb)
      begin
         if (sel_mode)
            memory_extension_mode_reg <= wr_byte[3:0];
         if (sel_pullup)
            pullup_option_reg <= wr_byte;
         if (sel_hold)
            hold_mode_reg <= wr_byte;
         if (sel_refresh)
            refresh_mode_reg <= wr_byte;
         if (sel_wait1)
            wait_control_reg_one <= wr_byte;
         if (sel_wait2)
            wait_control_reg_two <= wr_byte;
      end
   end

   // ========================================================================
   // Read mux; data registers read pins for inputs, latch for outputs
   // Port B pins read whether or not the converter samples them
   assign rd_byte = sel_a_data  ? a_rd
                  : sel_a_dir   ? a_dir
                  : sel_b_data  ? b_rd
                  : sel_b_dir   ? b_dir
                  : sel_mode    ? {4'h0, memory_extension_mode_reg}
                  : sel_pullup  ? pullup_option_reg
                  : sel_hold    ? hold_mode_reg
                  : sel_refresh ? refresh_mode_reg
                  : sel_wait1   ? wait_control_reg_one
                  : sel_wait2   ? wait_control_reg_two
                  : sel_status  ? a_ctl_mask
                  : 8'h00;

   // ========================================================================
   // Checks
   property p_addr_pins;
      @(posedge clk_i) disable iff (rst_i)
      (memory_extension_mode_reg == 4'h9)
         |-> (a_oe[3:0] == 4'hf) && (a_out[3:0] == upper_address_i);
   endproperty
   a_addr_pins: assert property (p_addr_pins)
      else $error("address pins not driven in mode 1001");

   property p_port_mode_free;
      @(posedge clk_i) disable iff (rst_i)
      (memory_extension_mode_reg == 4'h0) && !hold_en && !ext_wait_sel
         && !refresh_en |-> (a_oe == ~a_dir);
   endproperty
   a_port_mode_free: assert property (p_port_mode_free)
      else $error("plain port pins not following direction");

   property p_hold_latch;
      @(posedge clk_i) disable iff (rst_i)
      !a_latch_we[*2] |-> $stable(a_latch);
   endproperty
   a_hold_latch: assert property (p_hold_latch)
      else $error("latch changed without a write");

   property p_out_read;
      @(posedge clk_i) disable iff (rst_i)
      (!a_dir[0] && !a_ctl_mask[0]) |-> (a_rd[0] == a_latch[0])
                                      && (a_out[0] == a_latch[0]);
   endproperty
   a_out_read: assert property (p_out_read)
      else $error("output bit read or drive differs from latch");

   property p_in_read;
      @(posedge clk_i) disable iff (rst_i)
      (b_dir[3]) |-> (b_rd[3] == port_b_pins_i[3]) && !b_oe[3];
   endproperty
   a_in_read: assert property (p_in_read)
      else $error("input bit read is not the pin level");

   property p_write_all;
      @(posedge clk_i) disable iff (rst_i)
      (wr_stb && sel_b_data) |=> (b_latch == $past(wr_byte));
   endproperty
   a_write_all: assert property (p_write_all)
      else $error("port write missed a latch bit");

   property p_turn_out;
      @(posedge clk_i) disable iff (rst_i)
      $rose(!b_dir[5]) |-> b_oe[5] && (b_out[5] == b_latch[5]);
   endproperty
   a_turn_out: assert property (p_turn_out)
      else $error("turning to output did not drive latch");

   property p_bitop;
      @(posedge clk_i) disable iff (rst_i)
      (bitop_wr && !bitop_b) |=> (a_latch[$past(bitop_idx)]
                                  == $past(bitop_set));
   endproperty
   a_bitop: assert property (p_bitop)
      else $error("bit set/clear gave wrong latch bit");

   property p_ctl_read_zero;
      @(posedge clk_i) disable iff (rst_i)
      ((a_rd & a_ctl_mask) == 8'h00);
   endproperty
   a_ctl_read_zero: assert property (p_ctl_read_zero)
      else $error("control pin visible to software");

   property p_pullup;
      @(posedge clk_i) disable iff (rst_i)
      pullup_en ? (port_a_pullup_o == a_dir)
                : (port_a_pullup_o == 8'h00);
   endproperty
   a_pullup: assert property (p_pullup)
      else $error("pull-up does not follow input bits");

   property p_reset_dirs;
      @(posedge clk_i)
      rst_i ##1 !rst_i |-> (a_dir == 8'hff) && (b_dir == 8'hff)
                           && (a_oe == 8'h00) && (b_oe == 8'h00);
   endproperty
   a_reset_dirs: assert property (p_reset_dirs)
      else $error("ports not all inputs after reset");

   property p_hold_pins;
      @(posedge clk_i) disable iff (rst_i)
      hold_en |-> (bus_hold_request_o == port_a_pins_i[6])
                  && !a_oe[6] && a_oe[7] && (a_out[7] == bus_hold_ack_i);
   endproperty
   a_hold_pins: assert property (p_hold_pins)
      else $error("hold pins not in control mode");

   property p_refresh_pin;
      @(posedge clk_i) disable iff (rst_i)
      (refresh_en && !hold_en) |-> a_oe[7] && (a_out[7] == refresh_pulse_i);
   endproperty
   a_refresh_pin: assert property (p_refresh_pin)
      else $error("refresh pin not driven");

   property p_wait_in;
      @(posedge clk_i) disable iff (rst_i)
      (ext_wait_sel || a_dir[6]) |-> (ext_wait_n_o == port_a_pins_i[6]);
   endproperty
   a_wait_in: assert property (p_wait_in)
      else $error("wait input not following bit 6");

endmodule

// ### verif/dgp_board_model.sv
// Board circuitry facing one GPIO port: resolves each pin wire level.
// Assumes the bench supplies the level an outside driver puts on free pins.
`timescale 1ns/1ps

module dgp_board_model
(
   input  wire dgp_pkg::dgp_pins_s drv_i,
   input  wire logic [7:0]         pullup_i,
   input  wire logic [7:0]         ext_i,
   output logic      [7:0]         pin_o
);
   import dgp_pkg::*;
   // ======================================================================
   // Wire level
   // Chip driver wins; a pulled-up free pin reads high, others the board
   assign pin_o = (drv_i.oe & drv_i.out) | (~drv_i.oe & (pullup_i | ext_i));
endmodule

// ### verif/dgp_gpio_tb_top.sv
// Self-checking bench for the dual GPIO port over classic Wishbone.
// Assumes one 200 MHz clock and board models on both ports.
`timescale 1ns/1ps

module dgp_gpio_tb_top;
   import dgp_pkg::*;
   logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, hrq, wtn;
   logic [7:0]  adr = 0, ext_a = 0, ext_b = 0, v, vb, pua, pin_a, pin_b, ana;
   logic [3:0]  ua = 0, ctl = 0;
   logic [31:0] dat = 0, rdat, seed = 32'h3e937a23;
   dgp_pins_s   pa, pb;
   logic [7:0]  expq[$];
   int          n_mismatch = 0, checks_done = 0;

   always #2.5 clk_i = ~clk_i;

   dgp_gpio u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .port_a_pins_i(pin_a), .port_a_pins_o(pa), .port_a_pullup_o(pua),
      .port_b_pins_i(pin_b), .port_b_pins_o(pb), .analog_inputs_o(ana),
      .upper_address_i(ua), .read_strobe_n_i(ctl[0]), .write_strobe_n_i(ctl[1]),
      .bus_hold_ack_i(ctl[2]), .refresh_pulse_i(ctl[3]), .bus_hold_request_o(hrq),
      .ext_wait_n_o(wtn));
   dgp_board_model u_board_a (.drv_i(pa), .pullup_i(pua), .ext_i(ext_a), .pin_o(pin_a));
   dgp_board_model u_board_b (.drv_i(pb), .pullup_i(8'h00), .ext_i(ext_b), .pin_o(pin_b));

   // ======================================================================
   // Helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask

   task automatic complete_run();
      chk("pending reads", 8'h00, 8'(expq.size()));
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // One classic cycle; ack sampled at rising edges, released after the ack edge
   task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
      int n;
      n = 0;
      adr <= a;
      we  <= w;
      dat <= {24'h0, d};
      cyc <= 1'b1;
      stb <= 1'b1;
      do
      begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (ack !== 1'b1)
      begin
         n_mismatch++;
         complete_run();
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      expq.push_back(e);
      bus(a, 1'b0, 8'h00);
   endtask

   // Read results taken at the ack edge, oldest note first
   always @(posedge clk_i)
      if (cyc === 1'b1 && ack === 1'b1 && we === 1'b0 && expq.size() > 0)
         chk("read data", expq.pop_front(), rdat[7:0]);

   // ======================================================================
   // Scenarios
   initial
   begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(8'h04, 8'hff);
      rd(8'h0c, 8'hff);
      chk("oe a", 8'h00, pa.oe);
      $display("test reset done");
      seed = lfsr(seed);
      v = seed[7:0];
      ctl <= seed[27:24];
      bus(8'h00, 1'b1, v);
      bus(8'h04, 1'b1, 8'h00);
      chk("out a", v, pa.out);
      rd(8'h00, v);
      ext_a <= seed[15:8];
      bus(8'h04, 1'b1, 8'hf0);
      bus(8'h14, 1'b1, 8'h40);
      chk("pullup a", 8'hf0, pua);
      chk("oe a", 8'h0f, pa.oe);
      rd(8'h00, {4'hf, v[3:0]});
      bus(8'h14, 1'b1, 8'h00);
      rd(8'h00, {ext_a[7:4], v[3:0]});
      bus(8'h04, 1'b1, 8'h00);
      bus(8'h28, 1'b1, 8'h0a);
      vb = v | 8'h04;
      rd(8'h00, vb);
      $display("test port a done");
      seed = lfsr(seed);
      ext_b <= seed[7:0];
      bus(8'h08, 1'b1, seed[15:8]);
      bus(8'h0c, 1'b1, 8'h0f);
      chk("oe b", 8'hf0, pb.oe);
      rd(8'h08, {seed[15:12], ext_b[3:0]});
      chk("analog", {seed[15:12], ext_b[3:0]}, ana);
      $display("test port b done");
      ua <= seed[19:16];
      bus(8'h10, 1'b1, 8'h09);
      chk("upper addr", {4'h0, ua}, {4'h0, pa.out[3:0]});
      rd(8'h00, {vb[7:6], 6'h00});
      bus(8'h10, 1'b1, 8'h08);
      rd(8'h00, {vb[7:6], 2'b00, vb[3:2], 2'b00});
      rd(8'h3c, 8'h00);
      $display("test control done");
      ext_a[6] <= 1'b0;
      bus(8'h10, 1'b1, 8'h06);
      bus(8'h18, 1'b1, 8'h01);
      chk("wait idle", 8'h01, {7'h0, wtn});
      chk("hold ack", {ctl[2], 7'h3f}, {pa.out[7], pa.oe[6:0]});
      ext_a[6] <= 1'b1;
      bus(8'h20, 1'b1, 8'h0c);
      chk("hold req", 8'h01, {7'h0, hrq});
      ext_a[6] <= 1'b0;
      bus(8'h18, 1'b1, 8'h00);
      bus(8'h1c, 1'b1, 8'h01);
      chk("wait in", 8'h00, {7'h0, wtn});
      chk("refresh", {5'h0, ctl[3], 2'b10}, {5'h0, pa.out[7], pa.oe[7], hrq});
      rd(8'h2c, 8'hf0);
      $display("test hold done");
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("oe after reset", 8'h00, pa.oe | pb.oe | pua);
      rd(8'h2c, 8'h00);
      $display("test reset again done");
      complete_run();
   end
endmodule
